/* src/t2wc_pkg.sv */
// package: register map, fields, modes and constants of the timer
package t2wc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_A   = 8'hb0; // waveform_control_a
    localparam logic [7:0] IDX_CTRL_B   = 8'hb1; // waveform_control_b
    localparam logic [7:0] IDX_COUNT    = 8'hb2; // counter value
    localparam logic [7:0] IDX_CMP_A    = 8'hb3; // compare_value_a
    localparam logic [7:0] IDX_CMP_B    = 8'hb4; // compare_value_b
    localparam logic [7:0] IDX_GEN_CTRL = 8'hb8; // general_timer_control
    localparam logic [7:0] IDX_PIN_CTRL = 8'hb9; // pin direction and level
    localparam logic [7:0] IDX_STATUS   = 8'hba; // event flags
    localparam int unsigned ADDR_W = 12;        // apb address width
    // field positions
    localparam int unsigned COM_A_LSB    = 6;   // output_mode_chan_a
    localparam int unsigned COM_B_LSB    = 4;   // output_mode_chan_b
    localparam int unsigned WGM_HIGH_BIT = 3;   // waveform_mode_high_bit
    localparam int unsigned PSR_BIT      = 1;   // async_prescaler_reset_bit
    localparam int unsigned DDR_LSB      = 0;   // direction bits a, b
    localparam int unsigned PORT_LSB     = 2;   // port levels a, b
    localparam int unsigned OVF_BIT      = 0;   // overflow_flag
    localparam int unsigned MATCH_LSB    = 1;   // match flags a, b
    // write masks and reset values
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3; // bits 3:2 stay zero
    localparam logic [7:0] CTRL_B_WMASK = 8'h0f; // mode bit and clock select
    localparam logic [7:0] PIN_WMASK    = 8'h0f; // two direction, two levels
    localparam logic [7:0] REG_RESET    = 8'h00; // all registers
    localparam logic [7:0] MAX_VAL      = 8'hff; // counter maximum
    localparam logic [7:0] BOTTOM_VAL   = 8'h00; // counter bottom
    // waveform modes
    typedef enum logic [2:0] {
        M_NORMAL   = 3'b000,
        M_PC_FF    = 3'b001,
        M_CTC      = 3'b010,
        M_FAST_FF  = 3'b011,
        M_RSV4     = 3'b100,
        M_PC_CMP   = 3'b101,
        M_RSV6     = 3'b110,
        M_FAST_CMP = 3'b111
    } t2wc_mode_t;
    // clock select codes
    typedef enum logic [2:0] {
        CS_STOP = 3'b000,
        CS_DIV1 = 3'b001,
        CS_D8   = 3'b010,
        CS_D32  = 3'b011,
        CS_D64  = 3'b100,
        CS_D128 = 3'b101,
        CS_D256 = 3'b110,
        CS_D1K  = 3'b111
    } t2wc_cs_t;
    // byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
endpackage

/* src/t2wc_top.sv */
// 8-bit timer with two compare outputs behind an apb slave
// Notes on behaviour
// - prescaler gives stop, /1, 8,32,64,128,256,1024
// - prescaler reset bit clears prescaler count
// - nonzero output mode overrides port function, except pwm a code 01 without high bit
// - pin driver enabled only by direction bit
// - non-pwm: 00 off, 01 toggle, 10 clear, 11 set
// - fast pwm a: 10 non-inverting, 11 inverting
// - pwm a code 01 toggles only if high bit
// - fast pwm: compare at top ignored, bottom kept
// - phase pwm a: 10 clear up, set down
// - phase pwm: compare at top acts at top
// - fast pwm b like a, 01 reserved
// - phase pwm b like a, 01 reserved
// - control a bits 3:2 read zero
// - mode is three bits over both controls
// - modes 0,2 immediate update, flag at max
// - phase: update top, flag bottom; fast: bottom
// - high mode bit at control b bit 3
// - clock select field picks ascending division
`timescale 1ns/1ps
`default_nettype none
module t2wc_top (
    input  wire logic                        pclk,          // 50 MHz clock
    input  wire logic                        presetn,       // async reset
    input  wire logic                        psel,          // apb select
    input  wire logic                        penable,       // apb enable
    input  wire logic                        pwrite,        // apb direction
    input  wire logic [t2wc_pkg::ADDR_W-1:0] paddr,         // byte address
    input  wire logic [31:0]                 pwdata,        // write data
    output logic      [31:0]                 prdata,        // read data
    output logic                             pready,        // always ready
    output logic                             pslverr,       // unmapped
    output logic                             compare_out_a, // pin a level
    output logic                             compare_oe_a,  // pin a drive
    output logic                             compare_out_b, // pin b level
    output logic                             compare_oe_b   // pin b drive
);
    import t2wc_pkg::*;

    // registers
    logic [7:0]  ctrl_a_q, ctrl_b_q;   // waveform controls
    logic [7:0]  cnt_q;                // counter
    logic [7:0]  buf_q [2];            // compare values as written
    logic [7:0]  act_q [2];            // compare values in use
    logic [3:0]  pin_q;                // direction and port levels
    logic [2:0]  stat_q;               // event flags
    logic [9:0]  pre_q;                // prescaler count
    logic        down_q;               // phase pwm counting down
    logic        block_q;              // counter write blocks next match
    logic [1:0]  oc_q, lvl_q, oe_q;    // compare state, pin level, drive
    logic [31:0] prdata_q;             // read data

    // apb decode
    wire wr_en   = psel & penable & pwrite;
    wire rd_set  = psel & ~penable & ~pwrite;
    wire sel_ca  = paddr == byte_addr(IDX_CTRL_A);
    wire sel_cb  = paddr == byte_addr(IDX_CTRL_B);
    wire sel_cnt = paddr == byte_addr(IDX_COUNT);
    wire sel_ma  = paddr == byte_addr(IDX_CMP_A);
    wire sel_mb  = paddr == byte_addr(IDX_CMP_B);
    wire sel_gen = paddr == byte_addr(IDX_GEN_CTRL);
    wire sel_pin = paddr == byte_addr(IDX_PIN_CTRL);
    wire sel_st  = paddr == byte_addr(IDX_STATUS);
    wire mapped  = sel_ca | sel_cb | sel_cnt | sel_ma | sel_mb | sel_gen
                 | sel_pin | sel_st;
    wire [7:0] wdat = pwdata[7:0];
    wire psr_wr  = wr_en & sel_gen & wdat[PSR_BIT];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_q;

    // mode and clock select
    t2wc_mode_t mode;
    t2wc_cs_t   cs;
    assign mode = t2wc_mode_t'({ctrl_b_q[WGM_HIGH_BIT], ctrl_a_q[1:0]});
    assign cs   = t2wc_cs_t'(ctrl_b_q[2:0]);
    wire is_fast = (mode == M_FAST_FF) | (mode == M_FAST_CMP);
    wire is_pc   = (mode == M_PC_FF) | (mode == M_PC_CMP);
    wire top_a   = (mode == M_CTC) | (mode == M_PC_CMP) | (mode == M_FAST_CMP);
    wire [7:0] top = top_a ? act_q[0] : MAX_VAL;

    // prescaler tap for the selected division
    function automatic logic tap(input t2wc_cs_t c, input logic [9:0] p);
        logic t;
        t = 1'b0;
        unique case (c)
            CS_STOP: t = 1'b0;
            CS_DIV1: t = 1'b1;
            CS_D8:   t = &p[2:0];
            CS_D32:  t = &p[4:0];
            CS_D64:  t = &p[5:0];
            CS_D128: t = &p[6:0];
            CS_D256: t = &p[7:0];
            CS_D1K:  t = &p[9:0];
        endcase
        return t;
    endfunction
    wire tick = tap(cs, pre_q);

    // counter events
    wire at_top  = cnt_q == top;
    wire at_bot  = cnt_q == BOTTOM_VAL;
    wire pc_down = (down_q & ~at_bot) | (~down_q & at_top);
    wire wrap    = tick & ~is_pc & at_top;       // next count is bottom
    wire top_evt = tick & is_pc & at_top & ~down_q;
    wire upd     = is_fast ? wrap : is_pc ? top_evt : 1'b1;
    wire ovf_set = is_pc ? (tick & down_q & at_bot)
                 : (mode == M_FAST_CMP) ? wrap
                 : (tick & cnt_q == MAX_VAL);
    wire cnt_wr  = wr_en & sel_cnt;
    wire [7:0] cnt_d = cnt_wr ? wdat
                     : ~tick ? cnt_q
                     : is_pc ? (pc_down ? cnt_q - 8'h01 : cnt_q + 8'h01)
                     : at_top ? BOTTOM_VAL : cnt_q + 8'h01;

    // next compare output level of one channel
    function automatic logic oc_next(
        input logic oc, input logic [1:0] com, input logic is_a,
        input logic wgm2, input logic fast, input logic pc,
        input logic hit, input logic wr, input logic tp,
        input logic dn, input logic cmptop);
        logic r;
        logic ign;
        r   = oc;
        ign = com[1] & cmptop;
        if (!fast && !pc) begin
            if (hit && com == 2'b01) begin
                r = ~oc;
            end else if (hit && com[1]) begin
                r = com[0];
            end
        end else if (com == 2'b01) begin
            if (is_a && wgm2 && hit) begin
                r = ~oc;
            end
        end else if (com[1] && fast) begin
            if (wr) begin
                r = ~com[0];
            end else if (hit && !ign) begin
                r = com[0];
            end
        end else if (com[1]) begin
            if (ign) begin
                if (tp) begin
                    r = ~com[0];
                end
            end else if (hit) begin
                r = dn ? ~com[0] : com[0];
            end
        end
        return r;
    endfunction

    // per-channel compare, output and pin logic
    logic [1:0] hit;
    logic [1:0] dis;                // pwm a code 01 without high bit leaves port in charge
    logic [1:0] oc_d, lvl_d;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            wire [1:0] com = (ch == 0) ? ctrl_a_q[COM_A_LSB +: 2]
                                       : ctrl_a_q[COM_B_LSB +: 2];
            assign hit[ch]   = tick & ~block_q & (cnt_q == act_q[ch]);
            assign oc_d[ch]  = oc_next(oc_q[ch], com, ch == 0,
                                       ctrl_b_q[WGM_HIGH_BIT], is_fast, is_pc,
                                       hit[ch], wrap, top_evt, down_q,
                                       act_q[ch] == top);
            assign dis[ch]   = (ch == 0) & (com == 2'b01) & (is_fast | is_pc)
                             & ~ctrl_b_q[WGM_HIGH_BIT];
            assign lvl_d[ch] = ((|com) & ~dis[ch]) ? oc_q[ch]
                                      : pin_q[PORT_LSB + ch];
            // double-buffered compare value
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    buf_q[ch] <= REG_RESET;
                    act_q[ch] <= REG_RESET;
                end else begin
                    if (wr_en & ((ch == 0) ? sel_ma : sel_mb)) begin
                        buf_q[ch] <= wdat;
                    end
                    if (upd) begin
                        act_q[ch] <= (wr_en & ((ch == 0) ? sel_ma : sel_mb))
                                     ? wdat : buf_q[ch];
                    end
                end
            end
        end
    endgenerate

    // control registers and pin direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q <= REG_RESET;
            ctrl_b_q <= REG_RESET;
            pin_q    <= REG_RESET[3:0];
        end else if (wr_en) begin
            if (sel_ca) begin
                ctrl_a_q <= wdat & CTRL_A_WMASK;
            end
            if (sel_cb) begin
                ctrl_b_q <= wdat & CTRL_B_WMASK;
            end
            if (sel_pin) begin
                pin_q <= wdat[3:0] & PIN_WMASK[3:0];
            end
        end
    end

    // prescaler, cleared by the reset bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 10'h000;
        end else if (psr_wr) begin
            pre_q <= 10'h000;
        end else begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // counter, direction and match block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= REG_RESET;
            down_q  <= 1'b0;
            block_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            down_q  <= tick ? (is_pc & pc_down) : down_q;
            block_q <= cnt_wr | (block_q & ~tick);
        end
    end

    // event flags: set wins over write-one-to-clear
    wire [2:0] st_set = {hit[1], hit[0], ovf_set};
    wire [2:0] st_clr = (wr_en & sel_st) ? wdat[2:0] : 3'b000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 3'b000;
        end else begin
            stat_q <= st_set | (stat_q & ~st_clr);
        end
    end

    // compare outputs and pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_q  <= 2'b00;
            lvl_q <= 2'b00;
            oe_q  <= 2'b00;
        end else begin
            oc_q  <= oc_d;
            lvl_q <= lvl_d;
            oe_q  <= pin_q[DDR_LSB +: 2];
        end
    end
    assign compare_out_a = lvl_q[0];
    assign compare_out_b = lvl_q[1];
    assign compare_oe_a  = oe_q[0];
    assign compare_oe_b  = oe_q[1];

    // read mux, captured in the setup cycle
    wire [7:0] rd_mux = sel_ca  ? ctrl_a_q
                      : sel_cb  ? ctrl_b_q
                      : sel_cnt ? cnt_q
                      : sel_ma  ? buf_q[0]
                      : sel_mb  ? buf_q[1]
                      : sel_pin ? {4'h0, pin_q}
                      : sel_st  ? {5'h00, stat_q}
                      : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_set) begin
            prdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_psr_write;
        wr_en && sel_gen && wdat[PSR_BIT];
    endsequence
    sequence s_ctc_top;
        mode == M_CTC && tick && at_top && !cnt_wr;
    endsequence

    property p_div1;
        cs == CS_DIV1 |-> tick;
    endproperty
    a_div1: assert property (p_div1) else $error("div1 no tick");
    property p_stop;
        cs == CS_STOP && !cnt_wr |-> !tick ##1 $stable(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped moved");
    property p_psr;
        s_psr_write |=> pre_q == 10'h000;
    endproperty
    a_psr: assert property (p_psr) else $error("prescaler kept");
    property p_override;
        ctrl_a_q[COM_A_LSB +: 2] != 2'b00 && !dis[0]
            |=> lvl_q[0] == $past(oc_q[0]);
    endproperty
    a_override: assert property (p_override) else $error("no ovr");
    property p_detach;
        dis[0] |=> lvl_q[0] == $past(pin_q[PORT_LSB]);
    endproperty
    a_detach: assert property (p_detach) else $error("not detached");
    property p_drive;
        !pin_q[DDR_LSB] ##1 !pin_q[DDR_LSB] |-> !compare_oe_a;
    endproperty
    a_drive: assert property (p_drive) else $error("drive on");
    property p_toggle;
        !is_fast && !is_pc && ctrl_a_q[COM_A_LSB +: 2] == 2'b01 && hit[0]
            |=> oc_q[0] != $past(oc_q[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    property p_fast_bottom;
        is_fast && ctrl_a_q[COM_A_LSB +: 2] == 2'b10 && wrap |=> oc_q[0];
    endproperty
    a_fast_bottom: assert property (p_fast_bottom) else $error("no set");
    property p_pc_up;
        is_pc && ctrl_a_q[COM_A_LSB +: 2] == 2'b10 && hit[0] && !down_q
            && act_q[0] != top |=> !oc_q[0];
    endproperty
    a_pc_up: assert property (p_pc_up) else $error("no clear up");
    property p_ctc;
        s_ctc_top |=> cnt_q == BOTTOM_VAL;
    endproperty
    a_ctc: assert property (p_ctc) else $error("ctc no clear");
    property p_ovf;
        mode == M_NORMAL && tick && cnt_q == MAX_VAL |=> stat_q[OVF_BIT];
    endproperty
    a_ovf: assert property (p_ovf) else $error("no overflow");
    property p_rsv;
        rd_set && sel_ca |=> prdata[3:2] == 2'b00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
endmodule
`default_nettype wire

/* dv/t2wc_pin_model.sv */
// external pin seen through the compare output driver
`timescale 1ns/1ps
`default_nettype none
module t2wc_pin_model (
    input  wire logic pclk,  // bench clock
    input  wire logic drive, // level from the timer
    input  wire logic oe,    // driver enable
    output logic      pin    // level on the wire
);
    logic last_q = 1'b0; // last driven level
    // remember what was driven last
    always_ff @(posedge pclk) begin
        if (oe) begin
            last_q <= drive;
        end
    end
    // no pull on the wire: an undriven pin shows a stale-value trap
    assign pin = oe ? drive : ~last_q;
endmodule
`default_nettype wire

/* dv/test_timer2_waveform_control.sv */
// self-checking bench of the timer against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module test_timer2_waveform_control;
    import t2wc_pkg::*;
    localparam int GAP  = 45;   // idle cycles of a waveform run
    localparam int LONG = 1950; // idle cycles of a prescaler run
    logic              pclk, presetn, psel, penable, pwrite; // apb side
    logic [ADDR_W-1:0] paddr;                   // byte address
    logic [31:0]       pwdata, prdata, rnd;     // data and random state
    logic              pready, pslverr, e;      // answer
    logic              out_a, oe_a, out_b, oe_b, pin_a, pin_b; // pins
    logic [7:0]        v;                       // read value
    int                n_fail, checked, t_run, m_cnt, n; // counters
    bit                m_oca, m_ocb, m_up, m_ovf; // model state
    int                divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0]        regs [8] = '{IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT,
        IDX_CMP_A, IDX_CMP_B, IDX_GEN_CTRL, IDX_PIN_CTRL, IDX_STATUS};
    // mode, code a, code b, compare a, compare b, start, reset first
    int runs [11][7] = '{'{0, 1, 3, 8'h15, 8'h1a, 8'h10, 0},
        '{0, 2, 1, 8'h12, 8'h20, 8'h10, 0}, '{0, 3, 2, 8'h14, 8'h18, 8'h10, 0},
        '{0, 0, 1, 8'hf8, 8'h02, 8'hf0, 0}, '{2, 1, 3, 8'h14, 8'h02, 8'h10, 0},
        '{3, 2, 3, 8'h05, 8'h08, 8'hf0, 0}, '{7, 2, 3, 8'h20, 8'h05, 8'h10, 0},
        '{3, 1, 1, 8'h05, 8'h08, 8'hf0, 0}, '{1, 2, 2, 8'hf8, 8'hff, 8'hf0, 1},
        '{5, 1, 2, 8'h20, 8'h20, 8'h18, 1},
        '{6, 1, 3, 8'h30, 8'h31, 8'h20, 0}};

    t2wc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_out_a(out_a), .compare_oe_a(oe_a),
        .compare_out_b(out_b), .compare_oe_b(oe_b));
    t2wc_pin_model i_pin_a (.pclk(pclk), .drive(out_a), .oe(oe_a),
        .pin(pin_a));
    t2wc_pin_model i_pin_b (.pclk(pclk), .drive(out_b), .oe(oe_b),
        .pin(pin_b));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // galois shift register for random pin settings
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // compare one register value
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t reg %h not %h", $time, got, exp);
        end
    endtask

    // compare one flag or pin
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t bit %b not %b", $time, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd,
                       output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       x;
        apb(1'b1, idx, d, r, x);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] r);
        logic x;
        apb(1'b0, idx, 8'h00, r, x);
    endtask

    // reset for five cycles, model back to its start
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        m_oca = 1'b0;
        m_ocb = 1'b0;
        m_up  = 1'b1;
    endtask

    // next compare state of one channel on one tick
    function automatic bit upd(bit oc, int code, bit isa, int mode, bit m,
                               bit up, bit at_top, bit bot, bit spec);
        bit fast;
        fast = (mode == 3 || mode == 7);
        if (mode % 2 == 0) begin // reserved modes run as normal
            if (m && code != 0)
                oc = (code == 1) ? ~oc : code == 3;
            return oc;
        end
        if (code == 1)
            return (isa && mode > 4 && m) ? ~oc : oc;
        if (code == 0)
            return oc;
        if (fast) begin
            if (m && !spec)
                oc = code == 3;
            if (bot)
                oc = code == 2;
        end else if (spec) begin
            if (at_top)
                oc = code == 2;
        end else if (m)
            oc = up ? code == 3 : code == 2;
        return oc;
    endfunction

    // advance the model counter and outputs by t ticks
    task automatic model(input int mode, ca, cb, ra, rb, t);
        int top;
        bit blk, ma, mb, at, fast, pc;
        top  = (mode == 2 || mode == 5 || mode == 7) ? ra : 255;
        fast = (mode == 3 || mode == 7);
        pc   = (mode == 1 || mode == 5);
        blk  = 1'b1; // first tick after a counter write has no match
        m_ovf = 1'b0;
        repeat (t) begin
            ma  = !blk && m_cnt == ra;
            mb  = !blk && m_cnt == rb;
            blk = 1'b0;
            at  = m_cnt == top;
            m_oca = upd(m_oca, ca, 1'b1, mode, ma, m_up, at, fast && at,
                        ra == top);
            m_ocb = upd(m_ocb, cb, 1'b0, mode, mb, m_up, at, fast && at,
                        rb == top);
            if (pc) begin
                if (m_up && at)
                    m_up = 1'b0;
                else if (!m_up && m_cnt == 0) begin
                    m_up  = 1'b1;
                    m_ovf = 1'b1;
                end
                m_cnt = m_up ? m_cnt + 1 : m_cnt - 1;
            end else begin
                if (mode == 7 ? at : m_cnt == 255)
                    m_ovf = 1'b1;
                m_cnt = at ? 0 : (m_cnt + 1) & 255;
            end
        end
    endtask

    // configure while stopped, run a fixed span, compare with the model
    task automatic run_case(input int mode, ca, cb, ra, rb, s, rst);
        logic [3:0] lv;
        if (rst != 0)
            do_reset;
        rnd = lfsr(rnd);
        lv  = rnd[3:0];
        wr(IDX_CTRL_B, 8'h00);
        wr(IDX_CTRL_A, 8'h00);
        wr(IDX_CMP_A, ra[7:0]);
        wr(IDX_CMP_B, rb[7:0]);
        wr(IDX_COUNT, s[7:0]);
        wr(IDX_PIN_CTRL, {4'h0, lv});
        wr(IDX_STATUS, 8'h07);
        wr(IDX_CTRL_A, {ca[1:0], cb[1:0], 2'b00, mode[1:0]});
        wr(IDX_CTRL_B, {4'h0, mode[2], 3'b001});
        repeat (GAP) @(posedge pclk);
        wr(IDX_CTRL_B, {4'h0, mode[2], 3'b000});
        rd(IDX_COUNT, v);
        m_cnt = s;
        model(mode, ca, cb, ra, rb, t_run);
        chk_reg(v, m_cnt[7:0]);
        rd(IDX_STATUS, v);
        chk_bit(v[OVF_BIT], m_ovf);
        chk_bit(oe_a, lv[0]);
        chk_bit(oe_b, lv[1]);
        if (lv[0])
            chk_bit(pin_a, (ca == 0 || (ca == 1 && mode[0] && mode < 4))
                    ? lv[2] : m_oca);
        if (lv[1])
            chk_bit(pin_b, cb != 0 ? m_ocb : lv[3]);
    endtask

    // print counts and verdict, end the run
    task automatic conclude;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // cut a hang short
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        conclude;
    end

    // main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        presetn = 1'b0;
        n_fail = 0;
        checked = 0;
        t_run = GAP + 3; // ticks from start write to stop write landing
        rnd = 32'ha98a342c;
        do_reset;
        foreach (regs[i]) begin
            rd(regs[i], v);
            chk_reg(v, REG_RESET);
        end
        wr(IDX_CTRL_A, 8'hff);
        rd(IDX_CTRL_A, v);
        chk_reg(v, 8'hf3);
        wr(IDX_CTRL_B, 8'hf8);
        rd(IDX_CTRL_B, v);
        chk_reg(v, 8'h08);
        wr(IDX_CTRL_A, 8'h00);
        apb(1'b1, 8'hb5, 8'h5a, v, e);
        chk_bit(e, 1'b1);
        apb(1'b0, 8'hb5, 8'h00, v, e);
        chk_bit(e, 1'b1);
        chk_reg(v, 8'h00);
        apb(1'b0, IDX_COUNT, 8'h00, v, e);
        chk_bit(e, 1'b0);
        foreach (runs[i])
            run_case(runs[i][0], runs[i][1], runs[i][2], runs[i][3],
                     runs[i][4], runs[i][5], runs[i][6]);
        wr(IDX_CTRL_A, 8'h00);
        // every divided prescaler tap, /8 to /1024, from a freshly reset prescaler
        for (int cs = 2; cs < 8; cs++) begin
            wr(IDX_CTRL_B, 8'h00);
            wr(IDX_COUNT, 8'h00);
            wr(IDX_GEN_CTRL, 8'h02);
            wr(IDX_CTRL_B, cs[7:0]);
            repeat (LONG) @(posedge pclk);
            wr(IDX_CTRL_B, 8'h00);
            rd(IDX_COUNT, v);
            // ticks seen while the prescaler count runs 3 .. LONG+5
            n = (LONG + 6) / divs[cs];
            chk_reg(v, n[7:0]);
        end
        conclude;
    end
endmodule
`default_nettype wire
